// File: logic/acp_pkg.sv
/*
 * Shared constants and types for the converter control-pin block:
 * register map, field positions, reset values, range codes and timing.
 * Assumes a single 40 MHz clock domain and a 32-bit AXI4-Lite slave port.
 */
package acp_pkg;

  // Register byte addresses
  localparam logic [31:0] CFG_OFS     = 32'h0000_0000;
  localparam logic [31:0] STAT_OFS    = 32'h0000_0004;
  localparam logic [31:0] RES_OFS     = 32'h0000_0008;

  // Configuration register field positions
  localparam int          CFG_HSPAN_BIT = 0;
  localparam int          CFG_SIGN_BIT  = 1;
  localparam int          CFG_SLEEP_BIT = 2;
  localparam int          CFG_FMT_BIT   = 3;
  localparam logic [3:0]  CFG_RST       = 4'h0;

  // Status register field positions
  localparam int          ST_BUSY_BIT   = 0;
  localparam int          ST_HOLD_BIT   = 1;
  localparam int          ST_RANGE_LSB  = 2;
  localparam int          ST_VREF_BIT   = 4;
  localparam int          ST_RBUF_BIT   = 5;
  localparam int          ST_TEMP_BIT   = 6;
  localparam int          ST_SWMODE_BIT = 7;
  localparam int          ST_SLEEP_BIT  = 8;
  localparam int          ST_RESET_BIT  = 9;

  // Decoded analog input ranges
  localparam logic [1:0]  RNG_0_5       = 2'h0;
  localparam logic [1:0]  RNG_0_10      = 2'h1;
  localparam logic [1:0]  RNG_PM5       = 2'h2;
  localparam logic [1:0]  RNG_WIDE      = 2'h3;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // Timing: conversion time in ns, rounded up to whole clock cycles
  localparam int          CLK_PERIOD_NS = 25;
  localparam int          CONV_TIME_NS  = 3000;
  localparam int          CONV_CYCLES   =
    (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int          DATA_W        = 16;
  localparam logic [15:0] DATA_ZERO     = 16'h0000;
  localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;

  // Effective mode settings, from pins or the software register
  typedef struct packed {
    logic code_fmt;
    logic sleep;
    logic signed_rng;
    logic high_span;
  } acp_cfg_s;

  typedef enum logic {CV_IDLE, CV_RUN} acp_conv_e;

endpackage : acp_pkg

// File: logic/acp_edge.sv
/*
 * Edge finder for synchronous pin levels: one-cycle rise and fall pulses.
 * Assumes inputs are already synchronous to MCLK.
 */
`timescale 1ns/1ps
module acp_edge #(
  parameter logic IDLE_LEVEL = 1'b0
) (
  input  wire logic MCLK,
  input  wire logic NRST,
  input  wire logic LEVEL,
  output logic      RISE,
  output logic      FALL
);

  logic prev_ff;

  // Idle level at reset keeps a pin that sits there from faking an edge
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      prev_ff <= IDLE_LEVEL;
    end else begin
      prev_ff <= LEVEL;
    end
  end

  assign RISE = LEVEL & ~prev_ff;
  assign FALL = ~LEVEL & prev_ff;

endmodule : acp_edge

// File: logic/acp_ctrl.sv
/*
 * Control-pin logic of a 16-bit sampling converter: output enable,
 * conversion start and busy, reset and sleep handling, reference power
 * controls, range decode and software configuration override.
 * Assumes all pins synchronous to MCLK, the converted code presented on
 * ANALOG_CODE at the end of a conversion, and an AXI4-Lite master that
 * keeps at most one write and one read outstanding.
 */
`timescale 1ns/1ps
module acp_ctrl
  import acp_pkg::*;
#(
  parameter int CONV_CYC = CONV_CYCLES
) (
  input  wire logic        MCLK,
  input  wire logic        NRST,
  input  wire logic        CS_N,
  input  wire logic        RD_N,
  input  wire logic        RESET_PIN,
  input  wire logic        SLEEP_REQUEST,
  input  wire logic        SAMPLE_TRIGGER_N,
  input  wire logic        HIGH_SPAN_SEL,
  input  wire logic        SIGNED_SEL,
  input  wire logic        VREF_OFF,
  input  wire logic        REFBUF_OFF,
  input  wire logic        PORT_STYLE_SEL,
  input  wire logic        CFG_SOURCE_SEL,
  input  wire logic        CODE_FORMAT_SEL,
  input  wire logic        SER_CLK_IN,
  input  wire logic [15:0] ANALOG_CODE,
  output logic      [15:0] DATA_OUT,
  output logic             DATA_OE_N,
  output logic             SER_CLK_GATED,
  output logic             BUSY,
  output logic             HOLD,
  output logic      [1:0]  RANGE_SEL,
  output logic             VREF_EN,
  output logic             REFBUF_EN,
  output logic             TEMP_EN,
  input  wire logic [31:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic      [1:0]  S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [31:0] S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic      [31:0] S_AXI_RDATA,
  output logic      [1:0]  S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);

  localparam int CW = $clog2(CONV_CYC + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(CONV_CYC - 1);
  localparam logic [CW-1:0] CNT_ZERO = '0;

  acp_cfg_s        cfg_ff;
  acp_cfg_s        pin_cfg;
  acp_cfg_s        eff_cfg;
  acp_conv_e       conv_ff;
  logic [CW-1:0]   cnt_ff;
  logic [15:0]     data_ff;
  logic            oe_n_ff;
  logic            sclk_ff;
  logic            busy_ff;
  logic            hold_ff;
  logic [1:0]      range_ff;
  logic            vref_ff;
  logic            rbuf_ff;
  logic            temp_ff;
  logic            sw_mode;
  logic            trig_fall;
  logic            rst_fall;
  logic            start_ok;
  logic            conv_done;
  logic [1:0]      nxt_range;

  // AXI slave state
  logic            awready_ff;
  logic            wready_ff;
  logic            aw_got_ff;
  logic            w_got_ff;
  logic [31:0]     awaddr_ff;
  logic [31:0]     wdata_ff;
  logic [3:0]      wstrb_ff;
  logic            bvalid_ff;
  logic [1:0]      bresp_ff;
  logic            arready_ff;
  logic            rvalid_ff;
  logic [31:0]     rdata_ff;
  logic [1:0]      rresp_ff;
  logic            wr_fire;
  logic [31:0]     stat_word;

  acp_edge #(.IDLE_LEVEL(1'b1)) u_trig_edge (
    .MCLK  (MCLK),
    .NRST  (NRST),
    .LEVEL (SAMPLE_TRIGGER_N),
    .RISE  (),
    .FALL  (trig_fall)
  );

  acp_edge #(.IDLE_LEVEL(1'b0)) u_rst_edge (
    .MCLK  (MCLK),
    .NRST  (NRST),
    .LEVEL (RESET_PIN),
    .RISE  (),
    .FALL  (rst_fall)
  );

  // Mode source: software register only in serial port with low source
  assign sw_mode = PORT_STYLE_SEL & ~CFG_SOURCE_SEL;
  assign pin_cfg = '{code_fmt:   CODE_FORMAT_SEL,
                     sleep:      SLEEP_REQUEST,
                     signed_rng: SIGNED_SEL,
                     high_span:  HIGH_SPAN_SEL};
  assign eff_cfg = sw_mode ? cfg_ff : pin_cfg;

  // Starts only when idle, awake and not held in reset
  assign start_ok  = trig_fall & ~eff_cfg.sleep & ~RESET_PIN;
  assign conv_done = (conv_ff == CV_RUN) & (cnt_ff == CNT_LAST);

  // Range decode from the two selects
  always_comb begin
    case ({eff_cfg.high_span, eff_cfg.signed_rng})
      2'b00:   nxt_range = RNG_0_5;
      2'b01:   nxt_range = RNG_0_10;
      2'b10:   nxt_range = RNG_PM5;
      default: nxt_range = RNG_WIDE;
    endcase
  end

  // Conversion sequencer; reset pin aborts with no result written
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      conv_ff <= CV_IDLE;
      cnt_ff  <= CNT_ZERO;
    end else if (RESET_PIN) begin
      conv_ff <= CV_IDLE;
      cnt_ff  <= CNT_ZERO;
    end else begin
      case (conv_ff)
        CV_IDLE: begin
          cnt_ff <= CNT_ZERO;
          if (start_ok) begin
            conv_ff <= CV_RUN;
          end
        end
        CV_RUN: begin
          // Sleep is not checked here, so a started conversion completes
          if (conv_done) begin
            conv_ff <= CV_IDLE;
            cnt_ff  <= CNT_ZERO;
          end else begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
        default: begin
          conv_ff <= CV_IDLE;
          cnt_ff  <= CNT_ZERO;
        end
      endcase
    end
  end

  // Busy and hold follow the sequencer, set at the start edge
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      busy_ff <= 1'b0;
      hold_ff <= 1'b0;
    end else if (RESET_PIN) begin
      busy_ff <= 1'b0;
      hold_ff <= 1'b0;
    end else if (conv_ff == CV_IDLE) begin
      busy_ff <= start_ok;
      hold_ff <= start_ok;
    end else begin
      busy_ff <= ~conv_done;
      hold_ff <= ~conv_done;
    end
  end

  // Result latch; falls with busy so its edge marks valid data
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      data_ff <= DATA_ZERO;
    end else if (rst_fall && eff_cfg.code_fmt) begin
      data_ff <= DATA_ZERO;
    end else if (conv_done && !RESET_PIN) begin
      // Twos complement is the binary code with its top bit inverted
      data_ff <= eff_cfg.code_fmt ? ANALOG_CODE :
                 {~ANALOG_CODE[15], ANALOG_CODE[14:0]};
    end
  end

  // Output bus and serial clock gating, both kept alive during sleep
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      oe_n_ff <= 1'b1;
      sclk_ff <= 1'b0;
    end else begin
      oe_n_ff <= CS_N | RD_N;
      sclk_ff <= SER_CLK_IN & ~CS_N & PORT_STYLE_SEL;
    end
  end

  // Reference, buffer and temperature sensor enables, range output
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      vref_ff  <= 1'b0;
      rbuf_ff  <= 1'b0;
      temp_ff  <= 1'b0;
      range_ff <= RNG_0_5;
    end else begin
      vref_ff  <= ~VREF_OFF;
      rbuf_ff  <= ~REFBUF_OFF;
      temp_ff  <= ~VREF_OFF & ~REFBUF_OFF;
      range_ff <= nxt_range;
    end
  end

  // Software configuration register; the reset pin's fall clears it
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      cfg_ff <= acp_cfg_s'(CFG_RST);
    end else if (rst_fall) begin
      cfg_ff <= acp_cfg_s'(CFG_RST);
    end else if (wr_fire && awaddr_ff == CFG_OFS && wstrb_ff[0]) begin
      cfg_ff <= acp_cfg_s'(wdata_ff[3:0]);
    end
  end

  // Write path: address and data taken in either order, answer after both
  assign wr_fire = aw_got_ff & w_got_ff & ~bvalid_ff;

  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      aw_got_ff  <= 1'b0;
      w_got_ff   <= 1'b0;
      awaddr_ff  <= WORD_ZERO;
      wdata_ff   <= WORD_ZERO;
      wstrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && awready_ff) begin
        awaddr_ff  <= S_AXI_AWADDR;
        aw_got_ff  <= 1'b1;
        awready_ff <= 1'b0;
      end
      if (S_AXI_WVALID && wready_ff) begin
        wdata_ff  <= S_AXI_WDATA;
        wstrb_ff  <= S_AXI_WSTRB;
        w_got_ff  <= 1'b1;
        wready_ff <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= (awaddr_ff == CFG_OFS) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_ff && S_AXI_BREADY) begin
        bvalid_ff  <= 1'b0;
        aw_got_ff  <= 1'b0;
        w_got_ff   <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff  <= 1'b1;
      end
    end
  end

  // Status word shows the block's live state
  always_comb begin
    stat_word                               = WORD_ZERO;
    stat_word[ST_BUSY_BIT]                  = busy_ff;
    stat_word[ST_HOLD_BIT]                  = hold_ff;
    stat_word[ST_RANGE_LSB+1:ST_RANGE_LSB]  = range_ff;
    stat_word[ST_VREF_BIT]                  = vref_ff;
    stat_word[ST_RBUF_BIT]                  = rbuf_ff;
    stat_word[ST_TEMP_BIT]                  = temp_ff;
    stat_word[ST_SWMODE_BIT]                = sw_mode;
    stat_word[ST_SLEEP_BIT]                 = eff_cfg.sleep;
    stat_word[ST_RESET_BIT]                 = RESET_PIN;
  end

  // Read path: one-cycle answer, unmapped addresses give SLVERR and zero
  always_ff @(posedge MCLK) begin
    if (!NRST) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= WORD_ZERO;
      rresp_ff   <= RESP_OKAY;
    end else if (S_AXI_ARVALID && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rresp_ff   <= RESP_OKAY;
      case (S_AXI_ARADDR)
        CFG_OFS:  rdata_ff <= {28'h000_0000, cfg_ff};
        STAT_OFS: rdata_ff <= stat_word;
        RES_OFS:  rdata_ff <= {16'h0000, data_ff};
        default: begin
          rdata_ff <= WORD_ZERO;
          rresp_ff <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid_ff && S_AXI_RREADY) begin
      rvalid_ff  <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  // Every output straight from a flop
  assign DATA_OUT      = data_ff;
  assign DATA_OE_N     = oe_n_ff;
  assign SER_CLK_GATED = sclk_ff;
  assign BUSY          = busy_ff;
  assign HOLD          = hold_ff;
  assign RANGE_SEL     = range_ff;
  assign VREF_EN       = vref_ff;
  assign REFBUF_EN     = rbuf_ff;
  assign TEMP_EN       = temp_ff;
  assign S_AXI_AWREADY = awready_ff;
  assign S_AXI_WREADY  = wready_ff;
  assign S_AXI_BRESP   = bresp_ff;
  assign S_AXI_BVALID  = bvalid_ff;
  assign S_AXI_ARREADY = arready_ff;
  assign S_AXI_RDATA   = rdata_ff;
  assign S_AXI_RRESP   = rresp_ff;
  assign S_AXI_RVALID  = rvalid_ff;

endmodule : acp_ctrl

// File: bench/acp_props.sv
/* Checker for the control-pin block, watching acp_ctrl ports only.
   Assumes every pin is synchronous to MCLK and NRST is active low. */
`timescale 1ns/1ps
module acp_props
  import acp_pkg::*;
#(
  parameter int CONV_CYC = CONV_CYCLES
) (
  input wire logic        MCLK,
  input wire logic        NRST,
  input wire logic        CS_N,
  input wire logic        RD_N,
  input wire logic        RESET_PIN,
  input wire logic        SLEEP_REQUEST,
  input wire logic        SAMPLE_TRIGGER_N,
  input wire logic        HIGH_SPAN_SEL,
  input wire logic        SIGNED_SEL,
  input wire logic        VREF_OFF,
  input wire logic        REFBUF_OFF,
  input wire logic        PORT_STYLE_SEL,
  input wire logic        CFG_SOURCE_SEL,
  input wire logic        CODE_FORMAT_SEL,
  input wire logic        SER_CLK_IN,
  input wire logic [15:0] DATA_OUT,
  input wire logic        DATA_OE_N,
  input wire logic        SER_CLK_GATED,
  input wire logic        BUSY,
  input wire logic        HOLD,
  input wire logic [1:0]  RANGE_SEL,
  input wire logic        VREF_EN,
  input wire logic        REFBUF_EN,
  input wire logic        TEMP_EN
);
  logic [15:0] busy_cnt_ff;
  logic        hw_mode;
  // Pins rule the settings except in serial software mode
  assign hw_mode = CFG_SOURCE_SEL | ~PORT_STYLE_SEL;
  // Busy stretch length; a plain repetition would need a huge count
  always_ff @(posedge MCLK) begin
    if (!NRST) busy_cnt_ff <= 16'h0000;
    else busy_cnt_ff <= BUSY ? busy_cnt_ff + 16'h0001 : 16'h0000;
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);
  // Idle, awake, out of reset, and a falling trigger
  sequence s_go;
    hw_mode && !SLEEP_REQUEST && !RESET_PIN && !BUSY
      && $fell(SAMPLE_TRIGGER_N);
  endsequence
  sequence s_run;
    (BUSY && HOLD) [*3];
  endsequence
  AST_OE: assert property ($past(NRST) |->
    DATA_OE_N == $past(CS_N | RD_N)) else $error("bus enable wrong");
  AST_SCLK: assert property ($past(NRST) |-> SER_CLK_GATED ==
    $past(SER_CLK_IN & ~CS_N & PORT_STYLE_SEL)) else $error("sclk gate");
  AST_ABORT: assert property (RESET_PIN |=> !BUSY && !HOLD)
    else $error("conversion not aborted");
  AST_ZERO: assert property ($fell(RESET_PIN) && hw_mode
    && CODE_FORMAT_SEL |=> DATA_OUT == DATA_ZERO) else $error("no zero");
  AST_SLEEP: assert property ($rose(BUSY) && $past(hw_mode)
    |-> !$past(SLEEP_REQUEST)) else $error("start while asleep");
  AST_CAUSE: assert property ($rose(BUSY) |->
    $past(SAMPLE_TRIGGER_N, 2) && !$past(SAMPLE_TRIGGER_N))
    else $error("start without trigger");
  AST_START: assert property (s_go |=> s_run)
    else $error("trigger not taken");
  AST_LEN: assert property ($fell(BUSY) && !$past(RESET_PIN)
    |-> busy_cnt_ff == CONV_CYC) else $error("busy length");
  AST_PWR: assert property ($past(NRST) |-> VREF_EN ==
    !$past(VREF_OFF) && REFBUF_EN == !$past(REFBUF_OFF))
    else $error("power enables");
  AST_TEMP: assert property ($past(NRST) |->
    TEMP_EN == !$past(VREF_OFF | REFBUF_OFF)) else $error("temp enable");
  AST_RANGE: assert property ($past(NRST) && $past(hw_mode) |->
    RANGE_SEL == {$past(HIGH_SPAN_SEL), $past(SIGNED_SEL)})
    else $error("range decode");
endmodule : acp_props

bind acp_ctrl acp_props #(.CONV_CYC(CONV_CYC)) i_props (
  .MCLK(MCLK), .NRST(NRST), .CS_N(CS_N), .RD_N(RD_N),
  .RESET_PIN(RESET_PIN), .SLEEP_REQUEST(SLEEP_REQUEST),
  .SAMPLE_TRIGGER_N(SAMPLE_TRIGGER_N), .HIGH_SPAN_SEL(HIGH_SPAN_SEL),
  .SIGNED_SEL(SIGNED_SEL), .VREF_OFF(VREF_OFF), .REFBUF_OFF(REFBUF_OFF),
  .PORT_STYLE_SEL(PORT_STYLE_SEL), .CFG_SOURCE_SEL(CFG_SOURCE_SEL),
  .CODE_FORMAT_SEL(CODE_FORMAT_SEL), .SER_CLK_IN(SER_CLK_IN),
  .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N),
  .SER_CLK_GATED(SER_CLK_GATED), .BUSY(BUSY), .HOLD(HOLD),
  .RANGE_SEL(RANGE_SEL), .VREF_EN(VREF_EN), .REFBUF_EN(REFBUF_EN),
  .TEMP_EN(TEMP_EN));

// File: bench/acp_host.sv
/* Host trigger model: drives the conversion start pin low for two cycles.
   Assumes GO is a one-cycle request synchronous to MCLK. */
`timescale 1ns/1ps
module acp_host (
  input  wire logic MCLK,
  input  wire logic GO,
  output logic      TRIG_N
);
  logic [1:0] low_cnt_ff = 2'h0;
  // Pin returns high between requests so each start is a true fall
  always @(posedge MCLK) begin
    if (GO) low_cnt_ff <= 2'h2;
    else if (low_cnt_ff != 2'h0) low_cnt_ff <= low_cnt_ff - 2'h1;
  end
  assign TRIG_N = (low_cnt_ff == 2'h0);
endmodule : acp_host

// File: bench/tb_top.sv
/* Self-checking bench for acp_ctrl with a host trigger model.
   Assumes a 40 MHz MCLK and the AXI4-Lite timing of the design notes. */
`timescale 1ns/1ps
module tb_top
  import acp_pkg::*;
;
  localparam int CC = 8;
  logic MCLK = 1'b0, NRST = 1'b0, CS_N = 1'b1, RD_N = 1'b1, GO = 1'b0;
  logic RESET_PIN = 1'b0, SLEEP_REQUEST = 1'b0, SER_CLK_IN = 1'b0;
  logic HIGH_SPAN_SEL = 1'b0, SIGNED_SEL = 1'b0, PORT_STYLE_SEL = 1'b0;
  logic VREF_OFF = 1'b1, REFBUF_OFF = 1'b1, CFG_SOURCE_SEL = 1'b1;
  logic CODE_FORMAT_SEL = 1'b1, AWVALID = 1'b0, WVALID = 1'b0;
  logic BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic [15:0] ANALOG_CODE = 16'h0000;
  logic [31:0] AWADDR = WORD_ZERO, WDATA = WORD_ZERO, ARADDR = WORD_ZERO;
  logic SAMPLE_TRIGGER_N, DATA_OE_N, SER_CLK_GATED, BUSY, HOLD, VREF_EN;
  logic REFBUF_EN, TEMP_EN, AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [15:0] DATA_OUT;
  logic [1:0]  RANGE_SEL, BRESP, RRESP, r;
  logic [31:0] RDATA, d, seed = 32'h0000_DC10;
  logic [15:0] exp_q[$];
  logic [15:0] last_res = 16'h0000;
  logic [31:0] ex_w;
  logic [3:0]  WSTRB = 4'hF;
  int          errors = 0, total_checks = 0, cyc = 0;

  always #12.5 MCLK = ~MCLK;
  acp_host i_host (.MCLK(MCLK), .GO(GO), .TRIG_N(SAMPLE_TRIGGER_N));
  acp_ctrl #(.CONV_CYC(CC)) i_dut (
    .MCLK(MCLK), .NRST(NRST), .CS_N(CS_N), .RD_N(RD_N),
    .RESET_PIN(RESET_PIN), .SLEEP_REQUEST(SLEEP_REQUEST),
    .SAMPLE_TRIGGER_N(SAMPLE_TRIGGER_N), .HIGH_SPAN_SEL(HIGH_SPAN_SEL),
    .SIGNED_SEL(SIGNED_SEL), .VREF_OFF(VREF_OFF), .REFBUF_OFF(REFBUF_OFF),
    .PORT_STYLE_SEL(PORT_STYLE_SEL), .CFG_SOURCE_SEL(CFG_SOURCE_SEL),
    .CODE_FORMAT_SEL(CODE_FORMAT_SEL), .SER_CLK_IN(SER_CLK_IN),
    .ANALOG_CODE(ANALOG_CODE), .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N),
    .SER_CLK_GATED(SER_CLK_GATED), .BUSY(BUSY), .HOLD(HOLD),
    .RANGE_SEL(RANGE_SEL), .VREF_EN(VREF_EN), .REFBUF_EN(REFBUF_EN),
    .TEMP_EN(TEMP_EN), .S_AXI_AWADDR(AWADDR), .S_AXI_AWVALID(AWVALID),
    .S_AXI_AWREADY(AWREADY), .S_AXI_WDATA(WDATA), .S_AXI_WSTRB(WSTRB),
    .S_AXI_WVALID(WVALID), .S_AXI_WREADY(WREADY), .S_AXI_BRESP(BRESP),
    .S_AXI_BVALID(BVALID), .S_AXI_BREADY(BREADY), .S_AXI_ARADDR(ARADDR),
    .S_AXI_ARVALID(ARVALID), .S_AXI_ARREADY(ARREADY), .S_AXI_RDATA(RDATA),
    .S_AXI_RRESP(RRESP), .S_AXI_RVALID(RVALID), .S_AXI_RREADY(RREADY));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [31:0] a, v, output logic [1:0] rs);
    AWADDR <= a; WDATA <= v; AWVALID <= 1'b1; WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge MCLK);
      if (AWREADY === 1'b1) AWVALID <= 1'b0;
      if (WREADY === 1'b1) WVALID <= 1'b0;
    end while (BVALID !== 1'b1);
    rs = BRESP;
    BREADY <= 1'b0;
    @(posedge MCLK);
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] v,
                    output logic [1:0] rs);
    ARADDR <= a; ARVALID <= 1'b1; RREADY <= 1'b1;
    do begin
      @(posedge MCLK);
      if (ARREADY === 1'b1) ARVALID <= 1'b0;
    end while (RVALID !== 1'b1);
    v = RDATA; rs = RRESP;
    RREADY <= 1'b0;
    @(posedge MCLK);
  endtask : rd

  // One trigger; act 1 sleeps and act 2 resets in mid-conversion
  task automatic conv(input logic ef, input int ex_n, input int act);
    int n;
    logic [15:0] c;
    logic [31:0] w;
    w = xs();
    // Only the low half feeds the 16-bit converter code
    c = w[15:0];
    n = 0;
    ANALOG_CODE <= c;
    GO <= 1'b1;
    @(posedge MCLK);
    GO <= 1'b0;
    if (ex_n == CC) last_res = ef ? c : c ^ 16'h8000;
    exp_q.push_back(last_res);
    for (int i = 0; i < CC + 8; i++) begin
      @(posedge MCLK);
      // An unknown busy counts too, so it cannot pass as idle
      if (BUSY !== 1'b0) n++;
      if (i == 2 && act == 1) SLEEP_REQUEST <= 1'b1;
      if (i == 2 && act == 2) RESET_PIN <= 1'b1;
    end
    chk("busy cycles", ex_n, n);
    chk("result", exp_q.pop_front(), DATA_OUT);
  endtask : conv

  // Hang guard sized well above the whole sequence
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      complete_run();
    end
  end

  initial begin
    repeat (6) @(posedge MCLK);
    NRST <= 1'b1;
    @(posedge MCLK);
    rd(CFG_OFS, d, r); chk("cfg reset", WORD_ZERO, d);
    wr(CFG_OFS, 32'h0000_0009, r); chk("bresp", RESP_OKAY, r);
    rd(CFG_OFS, d, r);
    chk("cfg", 32'h0000_0009, d);
    // Low byte lane off: the write is answered but must not land
    WSTRB <= 4'hE;
    wr(CFG_OFS, 32'h0000_0006, r);
    chk("masked bresp", RESP_OKAY, r);
    WSTRB <= 4'hF;
    rd(CFG_OFS, d, r);
    chk("masked cfg", 32'h0000_0009, d);
    wr(STAT_OFS, WORD_ZERO, r); chk("ro bresp", RESP_SLVERR, r);
    rd(32'h0000_000C, d, r); chk("unmapped rresp", RESP_SLVERR, r);
    chk("unmapped data", WORD_ZERO, d);
    $display("test registers done");
    PORT_STYLE_SEL <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      d = xs();
      CS_N <= i[1]; RD_N <= i[0]; VREF_OFF <= i[1]; REFBUF_OFF <= i[0];
      HIGH_SPAN_SEL <= i[1]; SIGNED_SEL <= i[0]; SER_CLK_IN <= d[0];
      repeat (2) @(posedge MCLK);
      chk("oe_n", i != 0, DATA_OE_N);
      chk("range", i, RANGE_SEL);
      chk("vref", !i[1], VREF_EN);
      chk("refbuf", !i[0], REFBUF_EN);
      chk("temp", i == 0, TEMP_EN);
      chk("sclk", d[0] & !i[1], SER_CLK_GATED);
    end
    $display("test pins done");
    CS_N <= 1'b0; RD_N <= 1'b0; VREF_OFF <= 1'b0;
    REFBUF_OFF <= 1'b0;
    conv(1'b1, CC, 0);
    CODE_FORMAT_SEL <= 1'b0;
    conv(1'b0, CC, 0);
    conv(1'b0, CC, 1);
    conv(1'b0, 0, 0);
    rd(CFG_OFS, d, r); chk("cfg asleep", 32'h0000_0009, d);
    SLEEP_REQUEST <= 1'b0; CODE_FORMAT_SEL <= 1'b1;
    conv(1'b1, 3, 2);
    RESET_PIN <= 1'b0;
    repeat (2) @(posedge MCLK);
    last_res = DATA_ZERO;
    chk("reset zero", last_res, DATA_OUT);
    rd(CFG_OFS, d, r); chk("cfg cleared", WORD_ZERO, d);
    $display("test conversion done");
    CFG_SOURCE_SEL <= 1'b0; SIGNED_SEL <= 1'b1; SLEEP_REQUEST <= 1'b1;
    wr(CFG_OFS, 32'h0000_0001, r);
    repeat (2) @(posedge MCLK);
    chk("sw range", RNG_PM5, RANGE_SEL);
    conv(1'b0, CC, 0);
    wr(CFG_OFS, 32'h0000_0004, r);
    SLEEP_REQUEST <= 1'b0;
    conv(1'b0, 0, 0);
    // Status built from field positions: software mode, asleep, all on
    ex_w = WORD_ZERO;
    ex_w[ST_RANGE_LSB+:2] = RNG_0_5;
    ex_w[ST_VREF_BIT] = 1'b1;
    ex_w[ST_RBUF_BIT] = 1'b1;
    ex_w[ST_TEMP_BIT] = 1'b1;
    ex_w[ST_SWMODE_BIT] = 1'b1;
    ex_w[ST_SLEEP_BIT] = 1'b1;
    rd(STAT_OFS, d, r);
    chk("status", ex_w, d);
    rd(RES_OFS, d, r);
    chk("result reg", {16'h0000, last_res}, d);
    $display("test software mode done");
    complete_run();
  end
endmodule : tb_top
